// ===== common/spipc_pkg.sv
package spipc_pkg;
	// Synchroniser depth for pin inputs.
	localparam int SYNC_STAGES = 2;
	// Shift register width of one serial unit.
	localparam int SHIFT_BITS = 8;
	localparam logic [7:0] SHIFT_RESET = 8'h00;
	localparam logic [3:0] COUNT_RESET = 4'h0;
	// Pause state machine.
	typedef enum logic [1:0] {
		SPIPC_RUN = 2'b00,
		SPIPC_ARMED = 2'b01,
		SPIPC_PAUSED = 2'b10
	} spipc_state_type;
endpackage

// ===== hdl/spipc_sync.sv
`timescale 1ns/100ps
`default_nettype none
module spipc_sync #(
	parameter int WIDTH = 4
) (
	// Clock and reset.
	input wire logic i_clock,
	input wire logic i_rst,
	// Asynchronous pin levels and their synchronised copies.
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// Reset level of all pins is high so that select and pause read idle.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			meta_q <= '1;
			sync_q <= '1;
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;
endmodule // spipc_sync
`default_nettype wire

// ===== hdl/spipc_core.sv
//Function
// - Pause freezes sequence state without reset.
// - Pause while clock high waits falling edge.
// - Paused: ignore data, clock; output released.
// - Resume only on release while clock low.
// - Pause low releases output at once.
// - Sample on rise, drive after fall.
// - Deselected: standby, output high impedance.
`timescale 1ns/100ps
`default_nettype none
module spipc_core (
	// Clock and reset.
	input wire logic i_clock,
	input wire logic i_rst,
	// Serial pins from the host.
	input wire logic i_cs_n,
	input wire logic i_sck,
	input wire logic i_si,
	input wire logic i_pause_n,
	// Serial output pin with its enable.
	output logic o_so,
	output logic o_so_oe,
	// Link to the rest of the serial interface.
	input wire logic [spipc_pkg::SHIFT_BITS-1:0] i_tx_byte,
	output logic [spipc_pkg::SHIFT_BITS-1:0] o_rx_byte,
	output logic o_rx_valid,
	output logic o_tx_load,
	output logic o_paused,
	output logic o_selected
);
	import spipc_pkg::*;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [3:0] pins_sync;
	logic cs_n_s, sck_s, si_s, pause_n_s;

	spipc_sync #(.WIDTH(4)) spipc_sync_inst (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_async({i_cs_n, i_sck, i_si, i_pause_n}),
		.o_sync(pins_sync)
	);
	assign cs_n_s = pins_sync[3];
	assign sck_s = pins_sync[2];
	assign si_s = pins_sync[1];
	assign pause_n_s = pins_sync[0];

	// ------------------------------------------------------------
	// Edge detection and decode
	// ------------------------------------------------------------
	logic sck_prev_q;
	spipc_state_type state_q, state_d;
	logic [SHIFT_BITS-1:0] rx_q, tx_q;
	logic [3:0] count_q;

	wire selected = ~cs_n_s;
	wire sck_rise = sck_s & ~sck_prev_q;
	wire sck_fall = ~sck_s & sck_prev_q;
	wire running = selected & (state_q != SPIPC_PAUSED);
	// Edges count only while running; paused edges are dropped.
	wire do_sample = running & sck_rise;
	wire do_shift = running & sck_fall;
	wire byte_done = do_sample & (count_q == 4'(SHIFT_BITS - 1));

	// ------------------------------------------------------------
	// Pause state machine
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
			SPIPC_RUN: begin
				if (selected && !pause_n_s) begin
					// Clock high defers the pause to a falling edge.
					state_d = sck_s ? SPIPC_ARMED : SPIPC_PAUSED;
				end
			end
			SPIPC_ARMED: begin
				if (pause_n_s) begin
					state_d = SPIPC_RUN;
				end else if (sck_fall) begin
					state_d = SPIPC_PAUSED;
				end
			end
			SPIPC_PAUSED: begin
				// Release counts only with clock low.
				if (pause_n_s && !sck_s) begin
					state_d = SPIPC_RUN;
				end
			end
			default: begin
				state_d = SPIPC_RUN;
			end
		endcase
		// Deselect ends any pause; the host must not do this.
		if (!selected) begin
			state_d = SPIPC_RUN;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			state_q <= SPIPC_RUN;
			// Idle clock level of the synchroniser, so no edge after reset.
			sck_prev_q <= 1'b1;
		end else begin
			state_q <= state_d;
			sck_prev_q <= sck_s;
		end
	end

	// ------------------------------------------------------------
	// Shift registers; held while paused, cleared on deselect
	// ------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (i_rst || !selected) begin
			rx_q <= SHIFT_RESET;
			count_q <= COUNT_RESET;
		end else if (do_sample) begin
			// Paused state keeps count and bits, continues next bit.
			rx_q <= {rx_q[SHIFT_BITS-2:0], si_s};
			count_q <= byte_done ? COUNT_RESET : count_q + 4'h1;
		end
	end

	wire load_now = do_shift & (count_q == COUNT_RESET);

	always_ff @(posedge i_clock) begin
		if (i_rst || !selected) begin
			tx_q <= SHIFT_RESET;
		end else if (load_now) begin
			tx_q <= i_tx_byte;
		end else if (do_shift) begin
			tx_q <= {tx_q[SHIFT_BITS-2:0], 1'b0};
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Any low pause level releases the output, whatever the clock.
	wire so_enable = selected & pause_n_s & (state_q == SPIPC_RUN);

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_so <= 1'b0;
			o_so_oe <= 1'b0;
			o_rx_byte <= SHIFT_RESET;
			o_rx_valid <= 1'b0;
			o_tx_load <= 1'b0;
			o_paused <= 1'b0;
			o_selected <= 1'b0;
		end else begin
			o_so <= load_now ? i_tx_byte[SHIFT_BITS-1]
				: (do_shift ? tx_q[SHIFT_BITS-2] : o_so);
			o_so_oe <= so_enable;
			o_rx_byte <= byte_done ? {rx_q[SHIFT_BITS-2:0], si_s} : o_rx_byte;
			o_rx_valid <= byte_done;
			o_tx_load <= load_now;
			o_paused <= (state_q == SPIPC_PAUSED);
			o_selected <= selected;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence seq_armed_fall;
		state_q == SPIPC_ARMED && !pause_n_s && selected && sck_fall;
	endsequence

	chk_pause_so_off: assert property (
		@(posedge i_clock) disable iff (i_rst)
		!pause_n_s |=> !o_so_oe)
		else $error("output enabled while pause low");
	chk_deselect_so_off: assert property (
		@(posedge i_clock) disable iff (i_rst)
		!selected |=> !o_so_oe && !o_selected)
		else $error("output enabled while deselected");
	chk_defer_pause: assert property (
		@(posedge i_clock) disable iff (i_rst)
		state_q == SPIPC_RUN && selected && !pause_n_s && sck_s
		|=> state_q == SPIPC_ARMED)
		else $error("pause with clock high not deferred");
	chk_armed_enter: assert property (
		@(posedge i_clock) disable iff (i_rst)
		seq_armed_fall |=> state_q == SPIPC_PAUSED)
		else $error("deferred pause not taken at falling edge");
	chk_no_resume_high: assert property (
		@(posedge i_clock) disable iff (i_rst)
		state_q == SPIPC_PAUSED && selected && sck_s
		|=> state_q == SPIPC_PAUSED)
		else $error("resumed while clock high");
	chk_paused_hold: assert property (
		@(posedge i_clock) disable iff (i_rst)
		state_q == SPIPC_PAUSED && selected
		|=> $stable(rx_q) && $stable(count_q) && $stable(tx_q))
		else $error("shift state changed while paused");
	chk_sample_rise: assert property (
		@(posedge i_clock) disable iff (i_rst)
		do_sample |=> rx_q[0] == $past(si_s))
		else $error("input bit not sampled on rising edge");
	chk_resume_count: assert property (
		@(posedge i_clock) disable iff (i_rst)
		state_q == SPIPC_PAUSED && state_d == SPIPC_RUN
		|=> $stable(count_q))
		else $error("bit position lost on resume");
	chk_pause_keeps: assert property (
		@(posedge i_clock) disable iff (i_rst)
		state_q == SPIPC_RUN && state_d == SPIPC_PAUSED
		|=> count_q == $past(count_q))
		else $error("sequence reset on pause");
endmodule // spipc_core
`default_nettype wire

// ===== verif/spipc_host.sv
`timescale 1ns/100ps
`default_nettype none
module spipc_host (
	// Serial pins towards the device.
	output logic o_cs_n,
	output logic o_sck,
	output logic o_si,
	output logic o_pause_n,
	// Serial output from the device.
	input wire logic i_so,
	input wire logic i_so_oe
);
	logic [7:0] got;
	initial begin
		o_cs_n = 1'b1;
		o_sck = 1'b1;
		o_si = 1'b0;
		o_pause_n = 1'b1;
		got = 8'h00;
	end
	task automatic drv(input logic k, input logic s, input logic p);
		o_sck = k;
		o_si = s;
		o_pause_n = p;
	endtask
	task automatic rise();
		o_sck = 1'b1;
		#200;
		got = {got[6:0], i_so_oe ? i_so : ~i_so};
	endtask
	// A released data line is not left at its last value.
	task automatic sel(input logic on);
		o_cs_n = ~on;
		if (!on) o_si = ~o_si;
		#400;
	endtask
endmodule // spipc_host
`default_nettype wire

// ===== verif/spi_pause_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
$display("wrong value at %0t: %h %h", $time, (a), (b)); end end
module spi_pause_control_bench;
	import spipc_pkg::*;
	logic i_clock, i_rst, cs_n, sck, si, pz_n, so, oe, rxv, txl, pzd, sld;
	logic [7:0] tx_byte, rx_byte;
	int num_errors = 0;
	int n_tests = 0;
	int n_rxv = 0;
	int n_txl = 0;
	// Pulses are counted mid-cycle, away from the edge that launches them.
	always @(negedge i_clock) begin
		if (rxv) n_rxv <= n_rxv + 1;
		if (txl) n_txl <= n_txl + 1;
	end
	spipc_host spipc_host_inst (.o_cs_n(cs_n), .o_sck(sck), .o_si(si),
		.o_pause_n(pz_n), .i_so(so), .i_so_oe(oe));
	spipc_core spipc_core_inst (.i_clock(i_clock), .i_rst(i_rst),
		.i_cs_n(cs_n), .i_sck(sck), .i_si(si), .i_pause_n(pz_n),
		.o_so(so), .o_so_oe(oe), .i_tx_byte(tx_byte), .o_rx_byte(rx_byte),
		.o_rx_valid(rxv), .o_tx_load(txl), .o_paused(pzd), .o_selected(sld));
	initial begin
		i_clock = 1'b0;
		forever #25 i_clock = ~i_clock;
	end
	task automatic complete_run();
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Clock edges and data while paused must leave no trace.
	task automatic pause_low(input logic b);
		spipc_host_inst.drv(1'b0, b, 1'b1);
		#100 spipc_host_inst.drv(1'b0, b, 1'b0);
		#250;
		`CHK(oe, 1'b0)
		`CHK(pzd, 1'b1)
		repeat (2) begin
			spipc_host_inst.drv(1'b1, ~b, 1'b0);
			#200 spipc_host_inst.drv(1'b0, ~b, 1'b0);
			#200;
		end
		`CHK(oe, 1'b0)
		spipc_host_inst.drv(1'b0, b, 1'b1);
		#250;
		`CHK(pzd, 1'b0)
		`CHK(oe, 1'b1)
		spipc_host_inst.rise();
	endtask
	task automatic pause_high(input logic b);
		spipc_host_inst.drv(1'b1, si, 1'b0);
		#250;
		`CHK(oe, 1'b0)
		`CHK(pzd, 1'b0)
		spipc_host_inst.drv(1'b0, b, 1'b0);
		#250;
		`CHK(pzd, 1'b1)
		spipc_host_inst.drv(1'b1, b, 1'b0);
		#200 spipc_host_inst.drv(1'b1, b, 1'b1);
		#250;
		`CHK(pzd, 1'b1)
		spipc_host_inst.drv(1'b0, b, 1'b1);
		#250;
		`CHK(pzd, 1'b0)
		spipc_host_inst.rise();
	endtask
	task automatic run_byte(input logic [7:0] d, input int mode);
		int rxv0;
		int txl0;
		rxv0 = n_rxv;
		txl0 = n_txl;
		spipc_host_inst.sel(1'b1);
		`CHK(sld, 1'b1)
		for (int i = 7; i >= 0; i--) begin
			if (mode == 1 && i == 3) pause_low(d[i]);
			else if (mode == 2 && i == 3) pause_high(d[i]);
			else begin
				spipc_host_inst.drv(1'b0, d[i], 1'b1);
				#200 spipc_host_inst.rise();
			end
		end
		#100;
		`CHK(rx_byte, d)
		`CHK(spipc_host_inst.got, tx_byte)
		`CHK(n_rxv - rxv0, 1)
		`CHK(n_txl - txl0, 1)
		spipc_host_inst.sel(1'b0);
		`CHK(oe, 1'b0)
		`CHK(sld, 1'b0)
		$display("test mode %0d done", mode);
	endtask
	initial begin
		i_rst = 1'b1;
		tx_byte = 8'h3c;
		repeat (6) @(posedge i_clock);
		#1 i_rst = 1'b0;
		#200;
		run_byte(8'ha5, 0);
		run_byte(8'h96, 1);
		tx_byte = 8'hc3;
		run_byte(8'h5a, 2);
		complete_run();
	end
	initial begin
		#500000;
		num_errors++;
		complete_run();
	end
endmodule // spi_pause_control_bench
`default_nettype wire
